// >>> comparator_status_vref_regs.sv
// Register bank for two analog comparators: control, status with
// sticky flags, and reference voltage control. Avalon-MM slave.
// Assumes comparator outputs and wake events are asynchronous levels.
//
// Summary of operation
// - A comparator 0 wake event sets status bit 8.
// - A comparator 1 wake event sets status bit 9.
// - Wake and edge flags clear only when software writes a one.
// - Status bits 5 and 4 show synchronised comparator 1 and 0 outputs.
// - Comparator 1 output bit reads zero while comparator 1 is disabled.
// - Comparator 0 output bit reads zero while comparator 0 is disabled.
// - Bit 1 sets on the comparator 1 edge chosen by its bits 9:8.
// - Comparator 1 requests an interrupt while flag and enable are set.
// - Bit 0 sets on the chosen comparator 0 edge and may interrupt.
// - Reference bit 6 picks the analog supply or system reference.
// - Reference bits 3:0 set the level as source times 1/6 plus n/24.
// - Status at 0x08 and reference control at 0x0C reset to zero.
// - Edge select 00 is either edge, 01 rising, 10 falling, 11 none.
// - With wake enable set, interrupt enable also arms the wake flag.
//
// Chosen here: the Avalon-MM register port.
`include "csvr_map.svh"
module comparator_status_vref_regs (
	input  wire logic                sys_clk,
	input  wire logic                resetn,
	input  wire csvr_pkg::csvr_req_t avs,
	output csvr_pkg::csvr_rsp_t      avsRsp,
	input  wire logic [1:0]          cmpRaw,
	input  wire logic [1:0]          wakeEvent,
	output logic [1:0]               cmpEnableOut,
	output csvr_pkg::csvr_ref_t      refDrive,
	output logic [1:0]               cmpIrq,
	output logic                     irq,
	output logic [1:0]               wakeArmed
);
	import csvr_pkg::*;

	// ------------------------------------------------------------------
	// Byte-lane write helper
	// ------------------------------------------------------------------
	function automatic logic [31:0] laneMerge(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] be,
		input logic [31:0] mask);
		logic [31:0] m;
		m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & mask;
		laneMerge = (old & ~m) | (data & m);
	endfunction : laneMerge

	csvr_bus_state_t state_reg, state_next;
	logic            waitReq_reg, waitReq_next;
	logic [31:0]     ctl_reg [2];
	logic [31:0]     ctl_next [2];
	logic [31:0]     ref_reg,     ref_next;
	logic [1:0]      edgeF_reg,   edgeF_next;
	logic [1:0]      wakeF_reg,   wakeF_next;
	logic [31:0]     rdata_reg,   rdata_next;
	logic [1:0]      wm_reg,      wm_next;
	logic [1:0]      ws_reg,      ws_next;
	logic [1:0]      wp_reg,      wp_next;
	logic [1:0]      irqV_reg,    irqV_next;
	logic            irq_reg,     irq_next;
	logic [1:0]      armed_reg,   armed_next;
	logic [1:0]      syncOut;
	logic [1:0]      edgeEvent;
	logic [31:0]     status;
	logic            wrStatus;
	logic [3:0]      wrLane;
	logic [31:0]     clrBits;

	// ------------------------------------------------------------------
	// Comparator channels
	// ------------------------------------------------------------------
	for (genvar i = 0; i < 2; i++) begin : gChan
		csvr_cmp_chan uChan (
			.sys_clk    (sys_clk),
			.resetn     (resetn),
			.cmpRaw     (cmpRaw[i]),
			.cmpEnable  (ctl_reg[i][`CSVR_CTL_EN]),
			.edgeSelect (ctl_reg[i][`CSVR_CTL_EDGE_LO+1:`CSVR_CTL_EDGE_LO]),
			.syncOut    (syncOut[i]),
			.edgeEvent  (edgeEvent[i])
		);
	end

	always_comb begin
		status                 = '0;
		status[`CSVR_ST_EDGE0] = edgeF_reg[0];
		status[`CSVR_ST_EDGE1] = edgeF_reg[1];
		status[`CSVR_ST_OUT0]  = syncOut[0];
		status[`CSVR_ST_OUT1]  = syncOut[1];
		status[`CSVR_ST_WAKE0] = wakeF_reg[0];
		status[`CSVR_ST_WAKE1] = wakeF_reg[1];
	end

	// ------------------------------------------------------------------
	// Bus and register next state
	// ------------------------------------------------------------------
	// Write and read take one wait cycle, answered from the ACK state.
	always_comb begin
		state_next = state_reg;
		ctl_next   = ctl_reg;
		ref_next   = ref_reg;
		rdata_next = rdata_reg;
		wrStatus   = 1'b0;
		wrLane     = avs.byteenable;
		unique case (state_reg)
			CSVR_IDLE: begin
				if (avs.write) begin
					state_next = CSVR_ACK;
					unique case (avs.address)
						`CSVR_OFF_CTL0: ctl_next[0] = laneMerge(ctl_reg[0],
							avs.writedata, wrLane, `CSVR_CTL_MASK);
						`CSVR_OFF_CTL1: ctl_next[1] = laneMerge(ctl_reg[1],
							avs.writedata, wrLane, `CSVR_CTL_MASK);
						`CSVR_OFF_STATUS: wrStatus = 1'b1;
						`CSVR_OFF_REFCTL: ref_next = laneMerge(ref_reg,
							avs.writedata, wrLane, `CSVR_REF_MASK);
						default: ;
					endcase
				end else if (avs.read) begin
					state_next = CSVR_ACK;
					unique case (avs.address)
						`CSVR_OFF_CTL0:   rdata_next = ctl_reg[0];
						`CSVR_OFF_CTL1:   rdata_next = ctl_reg[1];
						`CSVR_OFF_STATUS: rdata_next = status;
						`CSVR_OFF_REFCTL: rdata_next = ref_reg;
						default:          rdata_next = '0;
					endcase
				end
			end
			CSVR_ACK: state_next = CSVR_IDLE;
		endcase
		// Registered so the bus sees a clean flip-flop output
		waitReq_next = (state_next != CSVR_ACK);
	end

	// ------------------------------------------------------------------
	// Sticky flags, wake synchroniser, interrupts
	// ------------------------------------------------------------------
	always_comb begin
		clrBits = laneMerge('0, avs.writedata, avs.byteenable, '1);
		if (!wrStatus) begin
			clrBits = '0;
		end
		wm_next = wakeEvent;
		ws_next = wm_reg;
		wp_next = ws_reg;
		for (int i = 0; i < 2; i++) begin
			armed_next[i] = ctl_reg[i][`CSVR_CTL_WAKE]
				& ctl_reg[i][`CSVR_CTL_IE];
			// Set wins over a same-cycle clear
			edgeF_next[i] = edgeEvent[i]
				| (edgeF_reg[i] & ~clrBits[`CSVR_ST_EDGE0+i]);
			wakeF_next[i] = (ws_reg[i] & ~wp_reg[i] & armed_reg[i])
				| (wakeF_reg[i] & ~clrBits[`CSVR_ST_WAKE0+i]);
			irqV_next[i]  = edgeF_next[i]
				& ctl_reg[i][`CSVR_CTL_IE];
		end
		irq_next = |irqV_next;
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			state_reg <= CSVR_IDLE;
			waitReq_reg <= 1'b1;
			ctl_reg   <= '{default: `CSVR_RST_VALUE};
			ref_reg   <= `CSVR_RST_VALUE;
			edgeF_reg <= '0;
			wakeF_reg <= '0;
			rdata_reg <= '0;
			wm_reg    <= '0;
			ws_reg    <= '0;
			wp_reg    <= '0;
			irqV_reg  <= '0;
			irq_reg   <= 1'b0;
			armed_reg <= '0;
		end else begin
			state_reg <= state_next;
			waitReq_reg <= waitReq_next;
			ctl_reg   <= ctl_next;
			ref_reg   <= ref_next;
			edgeF_reg <= edgeF_next;
			wakeF_reg <= wakeF_next;
			rdata_reg <= rdata_next;
			wm_reg    <= wm_next;
			ws_reg    <= ws_next;
			wp_reg    <= wp_next;
			irqV_reg  <= irqV_next;
			irq_reg   <= irq_next;
			armed_reg <= armed_next;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	// Waitrequest low only in ACK; readdata is registered there.
	assign avsRsp.readdata    = rdata_reg;
	assign avsRsp.waitrequest = waitReq_reg;
	assign cmpEnableOut = {ctl_reg[1][`CSVR_CTL_EN], ctl_reg[0][`CSVR_CTL_EN]};
	assign refDrive.sourceSelect = ref_reg[`CSVR_REF_SRC];
	assign refDrive.level        = ref_reg[3:0];
	assign cmpIrq    = irqV_reg;
	assign irq       = irq_reg;
	assign wakeArmed = armed_reg;
endmodule : comparator_status_vref_regs

// >>> comparator_status_vref_regs_test.sv
// Self-checking bench for the comparator status and reference block.
// Assumes the package, the design and the checker compile before it.
module comparator_status_vref_regs_test;
	timeunit 1ns;
	timeprecision 1ns;
	import csvr_pkg::*;
	logic        sys_clk = 1'b0;
	logic        resetn = 1'b0;
	csvr_req_t   avs = '0;
	csvr_rsp_t   avsRsp;
	logic [1:0]  cmpRaw = 2'h0;
	logic [1:0]  wakeEvent = 2'h0;
	logic [1:0]  cmpEnableOut, cmpIrq, wakeArmed;
	csvr_ref_t   refDrive;
	logic        irq;
	logic [31:0] q, st;
	int          mismatches = 0, n_compared = 0, seed = 70, s;

	always #4 sys_clk = ~sys_clk;

	comparator_status_vref_regs i_comparator_status_vref_regs (
		.sys_clk(sys_clk), .resetn(resetn), .avs(avs), .avsRsp(avsRsp),
		.cmpRaw(cmpRaw), .wakeEvent(wakeEvent), .cmpEnableOut(cmpEnableOut),
		.refDrive(refDrive), .cmpIrq(cmpIrq), .irq(irq), .wakeArmed(wakeArmed));

	// ----
	// Tasks
	// ----
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Request held until waitrequest is sampled low
	task acc(input logic w, input logic [5:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		avs <= '{a, ~w, w, 4'hF, d};
		do @(posedge sys_clk); while (avsRsp.waitrequest !== 1'b0);
		q = avsRsp.readdata;
		avs.read <= 1'b0;
		avs.write <= 1'b0;
	endtask : acc

	task rd(input logic [5:0] a, input logic [31:0] e);
		acc(1'b0, a, 32'h0);
		chk(q, e);
	endtask : rd

	task test_done;
		$display("Compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : test_done

	initial begin
		repeat (5000) @(posedge sys_clk);
		mismatches++;
		test_done;
	end

	// ----
	// Scenarios
	// ----
	initial begin
		repeat (3) @(posedge sys_clk);
		resetn <= 1'b1;
		rd(6'h08, 32'h0);
		rd(6'h0C, 32'h0);
		repeat (4) begin
			s = $random(seed);
			acc(1'b1, 6'h0C, s);
			rd(6'h0C, s & 32'h4F);
			chk(32'(refDrive), 32'({s[6], s[3:0]}));
		end
		rd(6'h30, 32'h0);
		$display("test registers done");
		for (int e = 0; e < 4; e++) begin
			acc(1'b1, 6'h00, 32'h3 | e << 8);
			acc(1'b1, 6'h04, 32'h3 | e << 8);
			@(posedge sys_clk) cmpRaw <= 2'h3;
			repeat (8) @(posedge sys_clk);
			st = (e < 2) ? 32'h33 : 32'h30;
			rd(6'h08, st);
			chk(32'(irq), 32'(st[0]));
			chk(32'(cmpIrq), st & 32'h3);
			@(posedge sys_clk) cmpRaw <= 2'h0;
			repeat (8) @(posedge sys_clk);
			st = st & 32'h3 | ((e == 0 || e == 2) ? 32'h3 : 32'h0);
			rd(6'h08, st);
			acc(1'b1, 6'h08, 32'h0);
			rd(6'h08, st);
			acc(1'b1, 6'h08, 32'h3);
			rd(6'h08, 32'h0);
		end
		$display("test edges done");
		@(posedge sys_clk) cmpRaw <= 2'h3;
		repeat (8) @(posedge sys_clk);
		rd(6'h08, 32'h30);
		acc(1'b1, 6'h04, 32'h300);
		rd(6'h08, 32'h10);
		acc(1'b1, 6'h00, 32'h300);
		rd(6'h08, 32'h0);
		$display("test gating done");
		@(posedge sys_clk) cmpRaw <= 2'h0;
		acc(1'b1, 6'h00, 32'h10302);
		acc(1'b1, 6'h04, 32'h10302);
		@(negedge sys_clk) chk(32'(wakeArmed), 32'h3);
		@(posedge sys_clk) wakeEvent <= 2'h3;
		repeat (8) @(posedge sys_clk);
		rd(6'h08, 32'h300);
		@(posedge sys_clk) wakeEvent <= 2'h0;
		acc(1'b1, 6'h08, 32'h100);
		rd(6'h08, 32'h200);
		acc(1'b1, 6'h08, 32'h200);
		rd(6'h08, 32'h0);
		$display("test wake done");
		acc(1'b1, 6'h0C, 32'h4F);
		@(posedge sys_clk) resetn <= 1'b0;
		repeat (3) @(posedge sys_clk);
		resetn <= 1'b1;
		rd(6'h0C, 32'h0);
		chk(32'(refDrive), 32'h0);
		rd(6'h08, 32'h0);
		$display("test reset done");
		test_done;
	end
endmodule : comparator_status_vref_regs_test

// >>> csvr_assertions.sv
// Concurrent checks on the comparator register bank ports.
// Assumes one clock domain and a synchronous active-low reset.
module csvr_assertions (
	input wire logic                sys_clk,
	input wire logic                resetn,
	input wire csvr_pkg::csvr_req_t avs,
	input wire csvr_pkg::csvr_rsp_t avsRsp,
	input wire logic [1:0]          cmpEnableOut,
	input wire csvr_pkg::csvr_ref_t refDrive,
	input wire logic [1:0]          cmpIrq,
	input wire logic                irq,
	input wire logic [1:0]          wakeArmed
);
	timeunit 1ns;
	timeprecision 1ns;
	import csvr_pkg::*;
	// ----
	// Bus phases
	// ----
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	wire logic rdAck = !avsRsp.waitrequest && avs.read;
	wire logic wrAck = !avsRsp.waitrequest && avs.write;
	sequence rdStat;
		rdAck && avs.address == 6'h08;
	endsequence
	sequence wrCtl0;
		wrAck && avs.address == 6'h00 && avs.byteenable[0];
	endsequence
	// ----
	// Checks
	// ----
	reset_zero_a: assert property ($rose(resetn) |->
		refDrive == 5'h00 && cmpEnableOut == 2'h0) else $error("not reset");
	ref_drive_a: assert property (wrAck && avs.address == 6'h0C &&
		avs.byteenable[0] |=> refDrive == {$past(avs.writedata[6]),
		$past(avs.writedata[3:0])}) else $error("reference drive wrong");
	stat_rsvd_a: assert property (rdStat |->
		(avsRsp.readdata & 32'hFFFF_FCCC) == 32'h0) else $error("status rsvd");
	ref_rsvd_a: assert property (rdAck && avs.address == 6'h0C |->
		(avsRsp.readdata & 32'hFFFF_FFB0) == 32'h0) else $error("ref rsvd");
	unmapped_zero_a: assert property (rdAck && avs.address > 6'h0C |->
		avsRsp.readdata == 32'h0) else $error("unmapped read not zero");
	out0_gate_a: assert property ((!cmpEnableOut[0]) [*4] ##0 rdStat |->
		!avsRsp.readdata[4]) else $error("output 0 not gated");
	out1_gate_a: assert property ((!cmpEnableOut[1]) [*4] ##0 rdStat |->
		!avsRsp.readdata[5]) else $error("output 1 not gated");
	enable_out_a: assert property (wrCtl0 |=>
		cmpEnableOut[0] == $past(avs.writedata[0])) else $error("enable lost");
	wake_arm_a: assert property (wrCtl0 ##0 avs.byteenable[2] |=>
		wakeArmed[0] == ($past(avs.writedata[16]) && $past(avs.writedata[1])))
		else $error("wake arming wrong");
	irq_merge_a: assert property (irq == (|cmpIrq))
		else $error("irq does not follow comparator requests");
endmodule : csvr_assertions

bind comparator_status_vref_regs csvr_assertions i_csvr_assertions (
	.sys_clk(sys_clk), .resetn(resetn), .avs(avs), .avsRsp(avsRsp),
	.cmpEnableOut(cmpEnableOut), .refDrive(refDrive), .cmpIrq(cmpIrq),
	.irq(irq), .wakeArmed(wakeArmed));

// >>> csvr_cmp_chan.sv
// One comparator channel: output synchroniser, enable gating and edge
// detection. Assumes the raw comparator output is asynchronous.
`include "csvr_map.svh"
module csvr_cmp_chan (
	input  wire logic       sys_clk,
	input  wire logic       resetn,
	input  wire logic       cmpRaw,
	input  wire logic       cmpEnable,
	input  wire logic [1:0] edgeSelect,
	output logic            syncOut,
	output logic            edgeEvent
);
	import csvr_pkg::*;

	logic       meta_reg,  meta_next;
	logic       sync_reg,  sync_next;
	logic       out_reg,   out_next;
	logic       evt_reg,   evt_next;
	logic       rise;
	logic       fall;

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		meta_next = cmpRaw;
		sync_next = meta_reg;
		out_next  = sync_reg & cmpEnable;
		rise      = out_next & ~out_reg;
		fall      = ~out_next & out_reg;
		unique case (edgeSelect)
			`CSVR_EDGE_BOTH: evt_next = rise | fall;
			`CSVR_EDGE_RISE: evt_next = rise;
			`CSVR_EDGE_FALL: evt_next = fall;
			default:         evt_next = 1'b0;        // Reserved code
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			out_reg  <= 1'b0;
			evt_reg  <= 1'b0;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
			out_reg  <= out_next;
			evt_reg  <= evt_next;
		end
	end

	assign syncOut   = out_reg;
	assign edgeEvent = evt_reg;
endmodule : csvr_cmp_chan

// >>> csvr_map.svh
// Register offsets, field positions and reset values of the comparator
// status and reference block. Included by the package and the design.
`ifndef CSVR_MAP_SVH
`define CSVR_MAP_SVH

// ----------------------------------------------------------------------
// Offsets (byte addresses)
// ----------------------------------------------------------------------
`define CSVR_OFF_CTL0     6'h00
`define CSVR_OFF_CTL1     6'h04
`define CSVR_OFF_STATUS   6'h08
`define CSVR_OFF_REFCTL   6'h0C

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define CSVR_CTL_EN       0
`define CSVR_CTL_IE       1
`define CSVR_CTL_EDGE_LO  8
`define CSVR_CTL_WAKE     16
`define CSVR_CTL_MASK     32'h0001_0303

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define CSVR_ST_EDGE0     0
`define CSVR_ST_EDGE1     1
`define CSVR_ST_OUT0      4
`define CSVR_ST_OUT1      5
`define CSVR_ST_WAKE0     8
`define CSVR_ST_WAKE1     9

// ----------------------------------------------------------------------
// Reference control fields
// ----------------------------------------------------------------------
`define CSVR_REF_SRC      6
`define CSVR_REF_MASK     32'h0000_004F

// ----------------------------------------------------------------------
// Reset values and edge-select codes
// ----------------------------------------------------------------------
`define CSVR_RST_VALUE    32'h0000_0000
`define CSVR_EDGE_BOTH    2'h0
`define CSVR_EDGE_RISE    2'h1
`define CSVR_EDGE_FALL    2'h2

`endif

// >>> csvr_pkg.sv
// Types shared by the comparator status and reference block.
// Assumes csvr_map.svh is on the include path.
package csvr_pkg;
	`include "csvr_map.svh"

	// ------------------------------------------------------------------
	// Avalon-MM slave request and answer
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [5:0]  address;
		logic        read;
		logic        write;
		logic [3:0]  byteenable;
		logic [31:0] writedata;
	} csvr_req_t;

	typedef struct packed {
		logic [31:0] readdata;
		logic        waitrequest;
	} csvr_rsp_t;

	// Reference generator drive
	typedef struct packed {
		logic       sourceSelect;
		logic [3:0] level;
	} csvr_ref_t;

	typedef enum logic [1:0] {
		CSVR_IDLE = 2'b00,
		CSVR_ACK  = 2'b01
	} csvr_bus_state_t;
endpackage : csvr_pkg
